// File: src/pfd_top.sv
`timescale 1ns/1ps
`include "pfd_params.svh"

// How it works
// - polarity high, main leads: increase output held high, decrease output pulses high.
// - polarity high, reference leads: decrease held low, increase output pulses low.
// - polarity low, main leads: decrease held low, increase output pulses low.
// - polarity low, reference leads: increase held high, decrease output pulses high.
// - in lock both correction outputs rest at their idle levels.
// - correction pulse width follows phase error; 180 degrees gives half duty.
// - monitor shows reference pulse when polarity high, main pulse when low.
// - an open polarity select input reads as high.
// - lock output high normally, low during any mismatch pulse.
// - lock output is the NOR of internal up and down.
// - strobe high or open: bypass pump mirrors primary pump.
// - strobe low: bypass pump floats, primary pump keeps working.
// - polarity low swaps correction outputs and primary pump direction.
// - compare only leading edges once per cycle, range minus to plus two pi.

module pfd_top
    import pfd_pkg::*;
(
    input  wire logic  ref_clk_i,
    input  wire logic  rst_n_i,
    input  wire logic  ref_div_pulse_i,
    input  wire logic  main_div_pulse_i,
    input  wire logic  polarity_select_i,
    input  wire logic  polarity_select_open_i,
    input  wire logic  latch_strobe_i,
    input  wire logic  latch_strobe_open_i,
    output logic       phase_inc_out_o,
    output logic       phase_dec_out_o,
    output logic       lock_indicator_o,
    output logic       divider_monitor_o,
    output logic       primary_pump_src_o,
    output logic       primary_pump_snk_o,
    output logic       primary_pump_oe_o,
    output logic       bypass_pump_src_o,
    output logic       bypass_pump_snk_o,
    output logic       bypass_pump_oe_o
);

    localparam int NPIN = 6;

    // pin synchronisers: 0 ref, 1 main, 2 polarity, 3 polarity open,
    // 4 strobe, 5 strobe open; the open flags are pins as well, so they are
    // synchronised before the pull-up mux instead of being muxed raw
    logic [NPIN-1:0]  pin_raw;
    logic [NPIN-1:0]  sync_q1_reg;
    logic [NPIN-1:0]  sync_q2_reg;
    logic [NPIN-1:0]  sync_q1_next;
    logic [NPIN-1:0]  sync_q2_next;
    logic             ref_last_reg;
    logic             main_last_reg;
    logic             ref_last_next;
    logic             main_last_next;
    logic             pol_eff;
    logic             strobe_eff;

    assign pin_raw[0] = ref_div_pulse_i;
    assign pin_raw[1] = main_div_pulse_i;
    assign pin_raw[2] = polarity_select_i;
    assign pin_raw[3] = polarity_select_open_i;
    assign pin_raw[4] = latch_strobe_i;
    assign pin_raw[5] = latch_strobe_open_i;

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++)
        begin : g_sync
            always_comb
            begin
                sync_q1_next[gi] = pin_raw[gi];
                sync_q2_next[gi] = sync_q1_reg[gi];
            end
        end
    endgenerate

    // the open flag models the internal pull-up
    assign pol_eff    = sync_q2_reg[3] ? `PFD_PULLUP_LEVEL : sync_q2_reg[2];
    assign strobe_eff = sync_q2_reg[5] ? `PFD_PULLUP_LEVEL : sync_q2_reg[4];

    always_comb
    begin
        ref_last_next  = sync_q2_reg[0];
        main_last_next = sync_q2_reg[1];
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sync_q1_reg   <= 6'h00;
            sync_q2_reg   <= 6'h00;
            ref_last_reg  <= 1'b0;
            main_last_reg <= 1'b0;
        end
        else
        begin
            sync_q1_reg   <= sync_q1_next;
            sync_q2_reg   <= sync_q2_next;
            ref_last_reg  <= ref_last_next;
            main_last_reg <= main_last_next;
        end
    end

    pfd_core_if core_bus ();

    // rising edges only: the falling edge carries no phase information
    assign core_bus.ref_edge  = sync_q2_reg[0] & ~ref_last_reg;
    assign core_bus.main_edge = sync_q2_reg[1] & ~main_last_reg;

    pfd_core u_core
    (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .bus       (core_bus)
    );

    logic      up_w;
    logic      down_w;
    pfd_pump_t pump_dir;

    assign up_w   = core_bus.up;
    assign down_w = core_bus.down;

    logic      inc_reg;
    logic      inc_next;
    logic      dec_reg;
    logic      dec_next;
    logic      lock_reg;
    logic      lock_next;
    logic      mon_reg;
    logic      mon_next;
    pfd_pump_t prim_reg;
    pfd_pump_t prim_next;
    pfd_pump_t byp_reg;
    pfd_pump_t byp_next;
    logic      prim_oe_reg;
    logic      prim_oe_next;
    logic      byp_oe_reg;
    logic      byp_oe_next;

    // up = reference leads (VCO too slow), down = main leads (VCO too fast)
    always_comb
    begin
        pump_dir = PFD_PUMP_OFF;
        if (up_w && !down_w)
            pump_dir = pol_eff ? PFD_PUMP_SOURCE : PFD_PUMP_SINK;
        else if (down_w && !up_w)
            pump_dir = pol_eff ? PFD_PUMP_SINK : PFD_PUMP_SOURCE;
    end

    always_comb
    begin
        inc_next = `PFD_INC_IDLE;
        dec_next = `PFD_DEC_IDLE;
        if (pol_eff)
        begin
            dec_next = down_w;
            inc_next = ~up_w;
        end
        else
        begin
            inc_next = ~down_w;
            dec_next = up_w;
        end
        // pulse width is the time a flop stays set, i.e. the phase error
        lock_next = ~(up_w | down_w);
        mon_next  = pol_eff ? sync_q2_reg[0] : sync_q2_reg[1];
        prim_next = pump_dir;
        byp_next  = strobe_eff ? pump_dir : PFD_PUMP_OFF;
        // enables are registered so every pump pin comes straight off a flop
        prim_oe_next = (pump_dir != PFD_PUMP_OFF);
        byp_oe_next  = strobe_eff && (pump_dir != PFD_PUMP_OFF);
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            inc_reg  <= `PFD_INC_IDLE;
            dec_reg  <= `PFD_DEC_IDLE;
            lock_reg <= `PFD_LOCK_IDLE;
            mon_reg  <= 1'b0;
            prim_reg <= PFD_PUMP_OFF;
            byp_reg  <= PFD_PUMP_OFF;
            prim_oe_reg <= 1'b0;
            byp_oe_reg  <= 1'b0;
        end
        else
        begin
            inc_reg  <= inc_next;
            dec_reg  <= dec_next;
            lock_reg <= lock_next;
            mon_reg  <= mon_next;
            prim_reg <= prim_next;
            byp_reg  <= byp_next;
            prim_oe_reg <= prim_oe_next;
            byp_oe_reg  <= byp_oe_next;
        end
    end

    assign phase_inc_out_o    = inc_reg;
    assign phase_dec_out_o    = dec_reg;
    assign lock_indicator_o   = lock_reg;
    assign divider_monitor_o  = mon_reg;
    // the source code has only bit 0 set and the sink code only bit 1
    assign primary_pump_src_o = prim_reg[0];
    assign primary_pump_snk_o = prim_reg[1];
    assign primary_pump_oe_o  = prim_oe_reg;
    assign bypass_pump_src_o  = byp_reg[0];
    assign bypass_pump_snk_o  = byp_reg[1];
    assign bypass_pump_oe_o   = byp_oe_reg;

    a_lock_nor: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ##1 lock_indicator_o == !($past(up_w) || $past(down_w)))
        else $error("lock output is not the NOR of up and down");

    a_dec_pol_hi: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (pol_eff && down_w) |=> phase_dec_out_o)
        else $error("decrease output missing for main lead");

    a_inc_pol_hi: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (pol_eff && up_w) |=> !phase_inc_out_o)
        else $error("increase output missing for reference lead");

    a_inc_pol_lo: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (!pol_eff && down_w) |=> !phase_inc_out_o)
        else $error("swapped increase output wrong");

    a_dec_pol_lo: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (!pol_eff && up_w) |=> phase_dec_out_o)
        else $error("swapped decrease output wrong");

    a_idle_levels: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (!up_w && !down_w) |=> (phase_inc_out_o && !phase_dec_out_o && !primary_pump_oe_o))
        else $error("outputs not idle while locked");

    a_bypass_off: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !strobe_eff |=> !bypass_pump_oe_o)
        else $error("bypass pump driven with strobe low");

    a_bypass_copy: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        strobe_eff |=> (bypass_pump_src_o == primary_pump_src_o
                        && bypass_pump_snk_o == primary_pump_snk_o))
        else $error("bypass pump differs from primary");

    a_pump_source: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (pol_eff && up_w && !down_w) |=> primary_pump_src_o)
        else $error("primary pump not sourcing");

    a_mon_select: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ##1 divider_monitor_o == ($past(pol_eff) ? $past(sync_q2_reg[0]) : $past(sync_q2_reg[1])))
        else $error("monitor shows wrong divider");

    c_ref_lead: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        up_w && !down_w ##1 !up_w);
    c_main_lead: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        down_w && !up_w ##1 !down_w);
    c_swapped: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !pol_eff && down_w);
    c_bypass_live: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        strobe_eff && bypass_pump_oe_o);

endmodule

// File: src/pfd_params.svh
`ifndef PFD_PARAMS_SVH
`define PFD_PARAMS_SVH

// level that an open pulled-up input reads as
`define PFD_PULLUP_LEVEL     1'b1
// idle levels of the correction outputs
`define PFD_INC_IDLE         1'b1
`define PFD_DEC_IDLE         1'b0
// lock output level while neither correction flop is set
`define PFD_LOCK_IDLE        1'b1
// synchroniser depth for pin inputs
`define PFD_SYNC_STAGES      2

`endif

// File: src/pfd_pkg.sv
package pfd_pkg;

    // drive state of a tri-state charge pump output
    typedef enum logic [1:0]
    {
        PFD_PUMP_OFF    = 2'b00,
        PFD_PUMP_SOURCE = 2'b01,
        PFD_PUMP_SINK   = 2'b10
    } pfd_pump_t;

endpackage

// File: src/pfd_core_if.sv
`timescale 1ns/1ps

interface pfd_core_if;
    logic ref_edge;
    logic main_edge;
    logic up;
    logic down;

    modport core
    (
        input  ref_edge,
        input  main_edge,
        output up,
        output down
    );

    modport top
    (
        output ref_edge,
        output main_edge,
        input  up,
        input  down
    );
endinterface

// File: src/pfd_core.sv
`timescale 1ns/1ps

module pfd_core
    import pfd_pkg::*;
(
    input  wire logic  ref_clk_i,
    input  wire logic  rst_n_i,
    pfd_core_if.core   bus
);

    logic up_reg;
    logic up_next;
    logic down_reg;
    logic down_next;

    // both flops clear in the cycle both are set; a fresh edge in that same
    // cycle re-arms its flop so no leading edge is lost
    always_comb
    begin
        up_next   = up_reg | bus.ref_edge;
        down_next = down_reg | bus.main_edge;
        if (up_reg && down_reg)
        begin
            up_next   = bus.ref_edge;
            down_next = bus.main_edge;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            up_reg   <= 1'b0;
            down_reg <= 1'b0;
        end
        else
        begin
            up_reg   <= up_next;
            down_reg <= down_next;
        end
    end

    assign bus.up   = up_reg;
    assign bus.down = down_reg;

    a_both_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (up_reg && down_reg && !bus.ref_edge && !bus.main_edge) |=> (!up_reg && !down_reg))
        else $error("up and down not cleared together");

    a_ref_sets_up: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        bus.ref_edge |=> up_reg)
        else $error("reference edge did not set up");

    a_main_sets_dn: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        bus.main_edge |=> down_reg)
        else $error("main edge did not set down");

endmodule

// File: dv/pfd_pump_model.sv
`timescale 1ns/1ps

// far-side charge pump and loop filter: the filter node is a charge count
module pfd_pump_model
(
    input  wire logic          ref_clk_i,
    input  wire logic          rst_n_i,
    input  wire logic          pump_src_i,
    input  wire logic          pump_snk_i,
    input  wire logic          pump_oe_i,
    output logic signed [15:0] charge_o
);
    logic signed [15:0] charge_next;

    // a floating pump leaves the node alone; an unknown drive counts as nothing
    always_comb
    begin
        charge_next = charge_o;
        if (pump_oe_i === 1'b1 && pump_src_i === 1'b1 && pump_snk_i === 1'b0)
            charge_next = charge_o + 16'sd1;
        if (pump_oe_i === 1'b1 && pump_snk_i === 1'b1 && pump_src_i === 1'b0)
            charge_next = charge_o - 16'sd1;
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            charge_o <= 16'sh0000;
        else
            charge_o <= charge_next;
    end
endmodule

// File: dv/phase_frequency_detector_test.sv
`timescale 1ns/1ps

module phase_frequency_detector_test;
    logic clk, rst_n, ref_pin, main_pin, pol, pol_open, strobe, strobe_open;
    logic inc, dec, lock, mon, p_src, p_snk, p_oe, b_src, b_snk, b_oe;
    logic signed [15:0] charge, bcharge;
    logic [15:0]        dp, db;
    int                 bad_count, tests_run, n_inc, n_dec, n_lock, n_mon;

    pfd_top dut (.ref_clk_i(clk), .rst_n_i(rst_n), .ref_div_pulse_i(ref_pin),
        .main_div_pulse_i(main_pin), .polarity_select_i(pol),
        .polarity_select_open_i(pol_open), .latch_strobe_i(strobe),
        .latch_strobe_open_i(strobe_open), .phase_inc_out_o(inc), .phase_dec_out_o(dec),
        .lock_indicator_o(lock), .divider_monitor_o(mon), .primary_pump_src_o(p_src),
        .primary_pump_snk_o(p_snk), .primary_pump_oe_o(p_oe), .bypass_pump_src_o(b_src),
        .bypass_pump_snk_o(b_snk), .bypass_pump_oe_o(b_oe));
    pfd_pump_model pm (.ref_clk_i(clk), .rst_n_i(rst_n), .pump_src_i(p_src),
        .pump_snk_i(p_snk), .pump_oe_i(p_oe), .charge_o(charge));
    pfd_pump_model bm (.ref_clk_i(clk), .rst_n_i(rst_n), .pump_src_i(b_src),
        .pump_snk_i(b_snk), .pump_oe_i(b_oe), .charge_o(bcharge));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic tally_and_finish();
        if (bad_count == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // control pins need three cycles to reach the detector; five leaves margin
    task automatic set_mode(input logic p, input logic po, input logic s, input logic so);
        @(posedge clk);
        pol         <= p;
        pol_open    <= po;
        strobe      <= s;
        strobe_open <= so;
        repeat (5) @(posedge clk);
    endtask

    // one reference edge at cycle tr (3 high), one main edge at tm (5 high);
    // outputs are settled mid-cycle, so they are counted on the falling edge
    task automatic fire(input int tr, input int tm);
        logic signed [15:0] p0, b0;
        @(negedge clk);
        p0     = charge;
        b0     = bcharge;
        n_inc  = 0;
        n_dec  = 0;
        n_lock = 0;
        n_mon  = 0;
        for (int c = 0; c < 30; c++)
        begin
            @(posedge clk);
            ref_pin  <= (c >= tr) && (c < tr + 3);
            main_pin <= (c >= tm) && (c < tm + 5);
            @(negedge clk);
            n_inc  += int'(inc === 1'b0);
            n_dec  += int'(dec === 1'b1);
            n_lock += int'(lock === 1'b0);
            n_mon  += int'(mon === 1'b1);
        end
        dp   = 16'(charge - p0);
        db   = 16'(bcharge - b0);
    endtask

    task automatic sc_reset();
        check(16'({inc, dec, lock, p_oe, b_oe}), 16'h0014);
    endtask

    task automatic sc_ref_leads();
        set_mode(1'b0, 1'b1, 1'b1, 1'b0);
        fire(0, 10);
        check(16'(n_inc), 16'd11);
        check(16'(n_dec), 16'd1);
        check(16'(n_lock), 16'd11);
        check(dp, 16'd10);
        check(db, 16'd10);
        check(16'(n_mon), 16'd3);
    endtask

    task automatic sc_main_leads();
        set_mode(1'b1, 1'b0, 1'b0, 1'b1);
        fire(10, 3);
        check(16'(n_dec), 16'd8);
        check(16'(n_inc), 16'd1);
        check(dp, -16'sd7);
        check(db, -16'sd7);
        check(16'(n_mon), 16'd3);
    endtask

    task automatic sc_low_pol();
        set_mode(1'b0, 1'b0, 1'b1, 1'b0);
        fire(2, 8);
        check(16'(n_dec), 16'd7);
        check(dp, -16'sd6);
        check(16'(n_mon), 16'd5);
        fire(9, 4);
        check(16'(n_inc), 16'd6);
        check(dp, 16'd5);
    endtask

    task automatic sc_half_cycle();
        set_mode(1'b1, 1'b0, 1'b1, 1'b0);
        fire(0, 10);
        check(16'(n_inc >= 10), 16'd1);
    endtask

    task automatic sc_coincident();
        set_mode(1'b1, 1'b0, 1'b1, 1'b0);
        fire(4, 4);
        check(16'({n_inc[3:0], n_dec[3:0], n_lock[3:0]}), 16'h0111);
        check(dp, 16'd0);
    endtask

    task automatic sc_bypass_off();
        set_mode(1'b1, 1'b0, 1'b0, 1'b0);
        fire(0, 6);
        check(dp, 16'd6);
        check(db, 16'd0);
    endtask

    initial
    begin
        {ref_pin, main_pin, pol_open, strobe_open} = '0;
        {pol, strobe} = 2'b11;
        {bad_count, tests_run} = '0;
        rst_n = 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        sc_reset();
        sc_ref_leads();
        sc_main_leads();
        sc_low_pol();
        sc_half_cycle();
        sc_coincident();
        sc_bypass_off();
        tally_and_finish();
    end

    // the sequence needs some 260 cycles; 5000 means a hang
    initial
    begin
        #500000;
        bad_count++;
        tally_and_finish();
    end
endmodule
